// ==== hw/rx_pkg.sv ====
// Purpose: shared constants for the receive filter and FIFO read block
// Assumes: 16-bit SPI words, command byte shifted first, MSB first
// Notes: filter command byte and slicer levels are local picks
package rx_pkg;
    // Command bytes in the upper half of the SPI word
    localparam logic [7:0] CMD_FIFO_READ = 8'hB0;
    localparam logic [7:0] CMD_FILTER_CFG = 8'hC2;
    // Power-on values
    localparam logic [15:0] FIFO_READ_RESET = 16'hB000;
    localparam logic [7:0] FILTER_CFG_RESET = 8'h2C;
    // Field layout of the filter word low byte
    localparam int QT_LSB = 0;
    localparam int QT_W = 3;
    localparam int RSV3_BIT = 3;
    localparam int FILTER_KIND_BIT = 4;
    localparam int RSV5_BIT = 5;
    localparam logic [7:0] FILTER_RSV_MASK = 8'h28;
    localparam logic FILTER_KIND_ANALOG = 1'b1;
    // SPI framing
    localparam int CMD_BITS = 8;
    localparam logic [4:0] WORD_BITS = 5'h10;
    localparam logic [4:0] LAST_CMD_BIT = 5'h07;
    localparam logic [4:0] DATA_START = 5'h08;
    // Digital RC model and slicer
    localparam int FILT_SHIFT = 3;
    localparam logic [7:0] SLICE_HI = 8'hA0;
    localparam logic [7:0] SLICE_LO = 8'h60;
    // Queue shape
    localparam int BYTE_W = 8;
    localparam int FIFO_DEPTH = 32;
endpackage

// ==== hw/byte_fifo.sv ====
// Purpose: synchronous FIFO with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: count output lets the owner judge fill level
`timescale 1ns/1ps
module byte_fifo #(
    parameter int W = 8,
    parameter int DEPTH = 32
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    // Level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [CW-1:0] count_ff;
    wire push = in_valid & in_ready;
    wire pop = out_valid & out_ready;

    // Honest flags from the level counter
    assign in_ready = (count_ff != CW'(DEPTH));
    assign out_valid = (count_ff != '0);
    assign out_data = mem[rd_ptr_ff];
    assign count = count_ff;

    // Storage has no reset, which keeps it plain RAM
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) wr_ptr_ff <= AW'(wr_ptr_ff + 1'b1);
            if (pop) rd_ptr_ff <= AW'(rd_ptr_ff + 1'b1);
            if (push && !pop) count_ff <= CW'(count_ff + 1'b1);
            else if (pop && !push) count_ff <= CW'(count_ff - 1'b1);
        end
    end
endmodule

// ==== hw/rx_filter_spi.sv ====
// Purpose: receive filter config and FIFO read over SPI command words
// Assumes: SPI mode 0, sck half period of at least four ref_clk cycles
// Notes: demodulator pins except fill_level_count are asynchronous and pass two flops
// How it works
// - Filter word bits 2..0 hold the quality threshold gating valid data.
// - Digital mode models an RC low-pass, sliced by a hysteresis comparator.
// - Command byte 10110000 in the upper half selects FIFO read.
// - FIFO read returns the oldest stored byte in the low eight bits.
// - Interrupt raised once stored bits reach a nonzero programmed fill count.
`timescale 1ns/1ps
module rx_filter_spi (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // SPI slave pins
    input wire logic spi_sck,
    input wire logic spi_sdi,
    input wire logic spi_cs_n,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Demodulator side
    input wire logic rx_clk,
    input wire logic rx_data,
    input wire logic [2:0] quality_level,
    input wire logic rx_queue_enable,
    input wire logic [3:0] fill_level_count,
    // Status and config view
    output logic fifo_irq,
    output logic rx_overflow,
    output logic sliced_data,
    output logic [2:0] quality_threshold,
    output logic filter_kind_select
);
    localparam int CW = $clog2(rx_pkg::FIFO_DEPTH+1);
    logic [8:0] sync1_ff, sync2_ff;
    logic sck_d_ff, cs_d_ff, rxclk_d_ff;
    logic [4:0] bit_cnt_ff;
    logic [15:0] shift_in_ff;
    logic [7:0] tx_ff;
    logic cmd_read_ff, had_data_ff, sdo_ff, sdo_oe_ff;
    logic [7:0] cfg_ff;
    logic [7:0] filt_ff;
    logic slice_ff;
    logic [7:0] asm_ff, hold_ff;
    logic [2:0] asm_cnt_ff;
    logic hold_valid_ff, overflow_ff, irq_ff;
    logic fifo_in_ready, fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic [CW-1:0] fifo_count;
    // Two-flop synchronisers, then edge history from the second stage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_ff <= 9'h040;
            sync2_ff <= 9'h040;
            // Idle pin levels, so no false edge follows reset
            sck_d_ff <= 1'b0;
            cs_d_ff <= 1'b1;
            rxclk_d_ff <= 1'b0;
        end else begin
            sync1_ff <= {spi_sck, spi_sdi, spi_cs_n, rx_clk, rx_data,
                         rx_queue_enable, quality_level};
            sync2_ff <= sync1_ff;
            sck_d_ff <= sync2_ff[8];
            cs_d_ff <= sync2_ff[6];
            rxclk_d_ff <= sync2_ff[5];
        end
    end

    // Clean copies and edge strobes, all from the second stage
    wire s_sck = sync2_ff[8];
    wire s_sdi = sync2_ff[7];
    wire s_cs_n = sync2_ff[6];
    wire s_rxclk = sync2_ff[5];
    wire s_rxdata = sync2_ff[4];
    wire s_en = sync2_ff[3];
    wire [2:0] s_quality = sync2_ff[2:0];
    wire cs_active = ~s_cs_n;
    wire sck_rise = s_sck & ~sck_d_ff & cs_active;
    wire sck_fall = ~s_sck & sck_d_ff & cs_active;
    wire cs_rise = s_cs_n & ~cs_d_ff;
    wire rx_rise = s_rxclk & ~rxclk_d_ff;

    wire [7:0] cmd_now = {shift_in_ff[6:0], s_sdi};
    wire cmd_done = sck_rise & (bit_cnt_ff == rx_pkg::LAST_CMD_BIT);
    wire is_read = (cmd_now == rx_pkg::CMD_FIFO_READ);
    // only a full sixteen-bit frame counts
    wire word_done = cs_rise & (bit_cnt_ff == rx_pkg::WORD_BITS);
    wire [7:0] word_cmd = shift_in_ff[15:rx_pkg::CMD_BITS];
    wire cfg_write = word_done & (word_cmd == rx_pkg::CMD_FILTER_CFG);
    // pop only after a completed read that found data
    wire pop = word_done & cmd_read_ff & had_data_ff;
    wire push = hold_valid_ff & fifo_in_ready;
    // Receive shifter; count saturates so long frames never match
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_ff <= 5'h00;
            shift_in_ff <= 16'h0000;
        end else if (!cs_active) begin
            bit_cnt_ff <= 5'h00;
        end else if (sck_rise) begin
            shift_in_ff <= {shift_in_ff[14:0], s_sdi};
            if (bit_cnt_ff != 5'h1F) bit_cnt_ff <= 5'(bit_cnt_ff + 1'b1);
        end
    end
    // latch oldest byte for the data half
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_read_ff <= 1'b0;
            had_data_ff <= 1'b0;
            tx_ff <= rx_pkg::FIFO_READ_RESET[7:0];
        end else if (cmd_done) begin
            cmd_read_ff <= is_read;
            had_data_ff <= is_read & fifo_out_valid;
            tx_ff <= (is_read & fifo_out_valid) ? fifo_out_data : 8'h00;
        end else if (sck_fall && bit_cnt_ff >= rx_pkg::DATA_START) begin
            tx_ff <= {tx_ff[6:0], 1'b0};
        end
    end
    // Output bit changes on the falling edge, ahead of host sampling
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_ff <= 1'b0;
            sdo_oe_ff <= 1'b0;
        end else begin
            sdo_oe_ff <= cs_active;
            if (!cs_active) sdo_ff <= 1'b0;
            else if (sck_fall && bit_cnt_ff >= rx_pkg::DATA_START)
                sdo_ff <= tx_ff[7];
        end
    end
    // reserved bits forced to one on every write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= rx_pkg::FILTER_CFG_RESET;
        end else if (cfg_write) begin
            cfg_ff <= shift_in_ff[7:0] | rx_pkg::FILTER_RSV_MASK;
        end
    end
    // first-order RC model, step is a fixed fraction of the error
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            filt_ff <= 8'h00;
        end else if (s_rxdata) begin
            filt_ff <= 8'(filt_ff + ((8'hFF - filt_ff) >> rx_pkg::FILT_SHIFT));
        end else begin
            filt_ff <= 8'(filt_ff - (filt_ff >> rx_pkg::FILT_SHIFT));
        end
    end
    // hysteresis slicer holds between the two levels
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            slice_ff <= 1'b0;
        end else if (filt_ff > rx_pkg::SLICE_HI) begin
            slice_ff <= 1'b1;
        end else if (filt_ff < rx_pkg::SLICE_LO) begin
            slice_ff <= 1'b0;
        end
    end
    // filter kind picks raw analog-filtered pin or slicer
    wire analog_sel = (cfg_ff[rx_pkg::FILTER_KIND_BIT] ==
                       rx_pkg::FILTER_KIND_ANALOG);
    wire chosen_bit = analog_sel ? s_rxdata : slice_ff;
    // threshold gate on the demodulator quality level
    wire [2:0] qt = cfg_ff[rx_pkg::QT_LSB +: rx_pkg::QT_W];
    wire quality_ok = (s_quality >= qt);
    // bits collected only while the queue is enabled
    wire take_bit = rx_rise & s_en & quality_ok;
    wire byte_done = take_bit & (asm_cnt_ff == 3'h7);
    // Byte assembly; disabling the queue drops a partial byte
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            asm_ff <= 8'h00;
            asm_cnt_ff <= 3'h0;
        end else if (!s_en) begin
            asm_cnt_ff <= 3'h0;
        end else if (take_bit) begin
            asm_ff <= {asm_ff[6:0], chosen_bit};
            asm_cnt_ff <= 3'(asm_cnt_ff + 1'b1);
        end
    end
    // Holding slot stalls on a full queue; a byte behind it is lost
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_ff <= 8'h00;
            hold_valid_ff <= 1'b0;
            overflow_ff <= 1'b0;
        end else begin
            if (byte_done && (!hold_valid_ff || fifo_in_ready)) begin
                hold_ff <= {asm_ff[6:0], chosen_bit};
                hold_valid_ff <= 1'b1;
            end else if (push) begin
                hold_valid_ff <= 1'b0;
            end
            // Set beats the enable-low clear
            if (byte_done && hold_valid_ff && !fifo_in_ready)
                overflow_ff <= 1'b1;
            else if (!s_en)
                overflow_ff <= 1'b0;
        end
    end
    // stored bits against the fill count
    wire [9:0] stored_bits = {1'b0, fifo_count, 3'b000} +
                             {7'h00, asm_cnt_ff};
    wire irq_now = (fill_level_count != 4'h0) &&
                   (stored_bits >= {6'h00, fill_level_count});
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) irq_ff <= 1'b0;
        else irq_ff <= irq_now;
    end
    // Queue of recovered bytes
    byte_fifo #(.W(rx_pkg::BYTE_W), .DEPTH(rx_pkg::FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(hold_valid_ff),
        .in_ready(fifo_in_ready),
        .in_data(hold_ff),
        .out_valid(fifo_out_valid),
        .out_ready(pop),
        .out_data(fifo_out_data),
        .count(fifo_count)
    );

    // Outputs straight from flops
    assign spi_sdo = sdo_ff;
    assign spi_sdo_oe = sdo_oe_ff;
    assign fifo_irq = irq_ff;
    assign rx_overflow = overflow_ff;
    assign sliced_data = slice_ff;
    assign quality_threshold = cfg_ff[rx_pkg::QT_LSB +: rx_pkg::QT_W];
    assign filter_kind_select = cfg_ff[rx_pkg::FILTER_KIND_BIT];

    // Checks on the block's own behaviour
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_rsv_set;
        cfg_ff[rx_pkg::RSV3_BIT] && cfg_ff[rx_pkg::RSV5_BIT];
    endproperty
    a_rsv_set: assert property (p_rsv_set)
        else $error("reserved filter bits not set");
    property p_cfg_write;
        cfg_write |=> quality_threshold == $past(shift_in_ff[2:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write)
        else $error("threshold not taken from write");
    property p_cmd_decode;
        cmd_done |=> cmd_read_ff == ($past(cmd_now) == 8'hB0);
    endproperty
    a_cmd_decode: assert property (p_cmd_decode)
        else $error("read command misdecoded");
    property p_tx_load;
        cmd_done && is_read && fifo_out_valid
            |=> tx_ff == $past(fifo_out_data);
    endproperty
    a_tx_load: assert property (p_tx_load)
        else $error("oldest byte not loaded");
    property p_pop_level;
        pop && !push |=> fifo_count == CW'($past(fifo_count) - 1'b1);
    endproperty
    a_pop_level: assert property (p_pop_level)
        else $error("read did not advance by one");
    property p_no_pop_empty;
        word_done && !had_data_ff && !push |=> $stable(fifo_count);
    endproperty
    a_no_pop_empty: assert property (p_no_pop_empty)
        else $error("empty read changed level");
    property p_slice_hi;
        filt_ff > rx_pkg::SLICE_HI |=> slice_ff;
    endproperty
    a_slice_hi: assert property (p_slice_hi)
        else $error("slicer missed high level");
    property p_slice_lo;
        filt_ff < rx_pkg::SLICE_LO |=> !slice_ff;
    endproperty
    a_slice_lo: assert property (p_slice_lo)
        else $error("slicer missed low level");
    property p_quality_gate;
        rx_rise && s_en && !quality_ok |=> $stable(asm_cnt_ff);
    endproperty
    a_quality_gate: assert property (p_quality_gate)
        else $error("low quality bit accepted");
    property p_irq;
        irq_now |=> fifo_irq;
    endproperty
    a_irq: assert property (p_irq)
        else $error("fill interrupt missing");
    c_read_data: cover property (pop);
    c_cfg_write: cover property (cfg_write);
    c_overflow: cover property ($rose(overflow_ff));
    c_irq: cover property ($rose(irq_ff));
endmodule

// ==== verif/spi_host_model.sv ====
// Purpose: behavioural host that frames 16-bit command words over SPI
// Assumes: mode 0, MSB first, sck period 160 ns (twenty cycles a half)
// Notes: short frames can be asked for to exercise frame rejection
`timescale 1ns/1ps
module spi_host_model (
    // Clock
    input wire logic ref_clk,
    // SPI pins
    input wire logic spi_sdo,
    output logic spi_sck,
    output logic spi_sdi,
    output logic spi_cs_n
);
    initial begin
        spi_sck = 1'b0;
        spi_sdi = 1'b1;
        spi_cs_n = 1'b1;
    end

    // command byte first, then eight data bits
    task automatic xfer(input logic [15:0] word, input int nbits,
                        output logic [7:0] rdata);
        rdata = 8'h00;
        @(posedge ref_clk);
        spi_cs_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < nbits; i++) begin
            spi_sdi <= word[15-i];
            repeat (20) @(posedge ref_clk);
            spi_sck <= 1'b1;
            // Device shifts on fall, so sample on our rise
            if (i >= 8) begin
                rdata = {rdata[6:0], spi_sdo};
            end
            repeat (20) @(posedge ref_clk);
            spi_sck <= 1'b0;
        end
        repeat (10) @(posedge ref_clk);
        spi_cs_n <= 1'b1;
        // Not selected: line shows inverse of last bit, no stale value
        spi_sdi <= ~word[16-nbits];
        repeat (10) @(posedge ref_clk);
    endtask
endmodule

// ==== verif/rx_baseband_filter_fifo_read_tb_top.sv ====
// Purpose: self-checking bench for filter config and FIFO read block
// Assumes: rx link bit period 160 ns, bits sampled on rx_clk rise
// Notes: a byte stalled behind a full queue waits in the hold slot
`timescale 1ns/1ps
module rx_baseband_filter_fifo_read_tb_top;
    logic ref_clk, rst_n, spi_sck, spi_sdi, spi_cs_n, spi_sdo;
    logic rx_clk, rx_data, rx_queue_enable, fifo_irq, rx_overflow;
    logic sliced_data, filter_kind_select, spi_sdo_oe;
    int oe_cnt = 0;
    logic [2:0] quality_level, quality_threshold, thr;
    logic [3:0] fill_level_count;
    logic [7:0] rd, b;
    logic [7:0] exp_q[$];
    int n_fail, compares, seed;

    rx_filter_spi dut_u (
        .ref_clk(ref_clk), .rst_n(rst_n), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_cs_n(spi_cs_n), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .rx_clk(rx_clk), .rx_data(rx_data),
        .quality_level(quality_level), .rx_queue_enable(rx_queue_enable),
        .fill_level_count(fill_level_count), .fifo_irq(fifo_irq),
        .rx_overflow(rx_overflow), .sliced_data(sliced_data),
        .quality_threshold(quality_threshold),
        .filter_kind_select(filter_kind_select)
    );

    spi_host_model host_u (
        .ref_clk(ref_clk), .spi_sdo(spi_sdo), .spi_sck(spi_sck),
        .spi_sdi(spi_sdi), .spi_cs_n(spi_cs_n)
    );

    // Clock at 4 ns period
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // Cycles in which the device drives its data pin
    always @(posedge ref_clk) begin
        if (spi_sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
    end

    // threshold from deviation, offset and bit rate
    function automatic logic [2:0] qt_of(int dev, int off, int rate);
        return 3'(4 * (dev - off) / rate);
    endfunction

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One byte MSB first on the recovered link, 160 ns per bit
    task automatic send_byte(input logic [7:0] v);
        for (int i = 7; i >= 0; i--) begin
            rx_data <= v[i];
            repeat (20) @(posedge ref_clk);
            rx_clk <= 1'b1;
            repeat (20) @(posedge ref_clk);
            rx_clk <= 1'b0;
        end
        repeat (6) @(posedge ref_clk);
    endtask

    task automatic final_report();
        if (n_fail == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Watchdog well past the expected run length
    initial begin
        repeat (90000) @(posedge ref_clk);
        n_fail++;
        final_report();
    end

    initial begin
        n_fail = 0;
        compares = 0;
        seed = 7;
        rst_n = 1'b0;
        rx_clk = 1'b0;
        rx_data = 1'b0;
        quality_level = 3'h7;
        rx_queue_enable = 1'b0;
        fill_level_count = 4'h0;
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check({5'h00, quality_threshold}, 8'h04);
        check({7'h00, filter_kind_select}, 8'h00);
        check({7'h00, spi_sdo_oe}, 8'h00);
        // Config writes, both filter kinds, random spare bits
        for (int i = 0; i < 4; i++) begin
            thr = (i == 0) ? qt_of(30, 5, 20) : 3'(5 + (i % 3));
            b = 8'($random(seed));
            b = {b[7:5], 1'(i), b[3], thr};
            host_u.xfer({rx_pkg::CMD_FILTER_CFG, b}, 16, rd);
            check({5'h00, quality_threshold}, {5'h00, thr});
            check({7'h00, filter_kind_select}, {7'h00, b[4]});
        end
        rx_queue_enable <= 1'b1;
        fill_level_count <= 4'hC;
        for (int i = 0; i < 2; i++) begin
            b = 8'($random(seed));
            exp_q.push_back(b);
            send_byte(b);
            check({7'h00, fifo_irq}, 8'(i));
        end
        // Bits under the threshold must not be stored
        quality_level <= thr - 3'h1;
        send_byte(8'h5A);
        quality_level <= 3'h7;
        // Unknown command and short frame leave the queue alone
        host_u.xfer(16'h5A00, 16, rd);
        check(rd, 8'h00);
        // Pin released between frames, driven through five whole frames
        check({7'h00, spi_sdo_oe}, 8'h00);
        check({7'h00, (oe_cnt >= 3200)}, 8'h01);
        host_u.xfer({rx_pkg::CMD_FIFO_READ, 8'h00}, 12, rd);
        for (int i = 0; i < 4; i++) begin
            host_u.xfer({rx_pkg::CMD_FIFO_READ, 8'h00}, 16, rd);
            check(rd, (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00);
        end
        // Fill past 32 words plus hold slot, then drain in order
        for (int i = 0; i < 35; i++) begin
            b = 8'($random(seed));
            if (i < 33) begin
                exp_q.push_back(b);
            end
            send_byte(b);
        end
        check({7'h00, rx_overflow}, 8'h01);
        for (int i = 0; i < 34; i++) begin
            host_u.xfer({rx_pkg::CMD_FIFO_READ, 8'h00}, 16, rd);
            check(rd, (exp_q.size() > 0) ? exp_q.pop_front() : 8'h00);
        end
        // Digital RC model and slicer follow a steady level
        host_u.xfer({rx_pkg::CMD_FILTER_CFG, 8'h05}, 16, rd);
        check({7'h00, filter_kind_select}, 8'h00);
        send_byte(8'hFF);
        send_byte(8'hFF);
        check({7'h00, sliced_data}, 8'h01);
        send_byte(8'h00);
        send_byte(8'h00);
        check({7'h00, sliced_data}, 8'h00);
        // Dropping the enable clears the lost-byte flag
        rx_queue_enable <= 1'b0;
        repeat (6) @(posedge ref_clk);
        check({7'h00, rx_overflow}, 8'h00);
        final_report();
    end
endmodule
